/* File: inc/uart_irq_defines.svh */
// Contract
// - All interrupt sources merge through one arbiter onto a single request.
// - An enabled pending source raises request; only the top-ranked one is shown in identification.
// - A disabled source is neither shown in identification nor requested.
// - Transmit-empty request rises when holding register or transmit FIFO empty.
// - Transmit-empty request is gated by its own enable bit.
// - Receive-data request: one character without FIFO, trigger level with FIFO.
// - Receive-data request is gated by the receive-data enable bit.
// - Data-ready flag shows only unread characters, never the trigger level.
// - Receive time-out request exists only while FIFOs are enabled.
// - Time-out after four idle character times with receive FIFO not empty.
// - Time-out fires even when the FIFO level is below trigger level.
// - Time-out shares the receive-data enable bit; no enable of its own.
// - No status flag shows time-out; only identification reveals it.
// - Line status request on overrun, parity, framing or break, if enabled.
// - Overrun, parity, framing and break bits readable in line status.
// - Modem request on CTS change without autoflow, or DSR, RI, DCD change.
// - Separate change flags for CTS, DSR, RI and DCD in modem status.
// - Three-bit type field: modem 0, transmit-empty 1, receive-data 2.
// - Line status outranks receive-data in the arbiter.
// - Four character times are 32, 36, 40 or 44 bits for 5 to 8 bits.
// - Character read, arrival or receiver reset clears time-out and timer.
`ifndef UART_IRQ_DEFINES_SVH
`define UART_IRQ_DEFINES_SVH

`define UART_OFS_ENABLE 8'h04
`define UART_OFS_IDENT 8'h08
`define UART_OFS_LINE 8'h14
`define UART_OFS_MODEM 8'h18

`define UART_EN_W 4
`define UART_EN_RST 4'h0
`define UART_EN_RX_DATA 0
`define UART_EN_TX_EMPTY 1
`define UART_EN_LINE 2
`define UART_EN_MODEM 3

`define UART_ID_NONE 0
`define UART_ID_TYPE_LO 1
`define UART_ID_FIFO_LO 6
`define UART_ID_RST 32'h0000_0001

`define UART_LS_READY 0
`define UART_LS_ERR_LO 1
`define UART_LS_TX_EMPTY 5

`define UART_MS_LVL_LO 4

`define UART_TO_BASE_BITS 6'h20
`define UART_TO_STEP_BITS 6'h04

`endif

/* File: inc/uart_irq_pkg.sv */
package uart_irq_pkg;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } line_err_s;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_s;

  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic tx_empty;
    logic modem_change;
  } req_s;

  typedef enum logic [2:0] {
    INT_MODEM = 3'h0,
    INT_TX_EMPTY = 3'h1,
    INT_RX_DATA = 3'h2,
    INT_LINE = 3'h3,
    INT_TIMEOUT = 3'h6
  } int_code_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ANSWER = 2'h2
  } apb_state_e;

endpackage : uart_irq_pkg

/* File: design/uart_irq_prio.sv */
`timescale 1ns/1ps
module uart_irq_prio
  import uart_irq_pkg::*;
(
  // Enabled requests
  input wire req_s req,
  // Winner
  output int_code_e code,
  output logic pending
);

  function automatic int_code_e pick(input req_s r);
    if (r.line_status) begin
      pick = INT_LINE;
    end else if (r.rx_data) begin
      pick = INT_RX_DATA;
    end else if (r.rx_timeout) begin
      pick = INT_TIMEOUT;
    end else if (r.tx_empty) begin
      pick = INT_TX_EMPTY;
    end else begin
      pick = INT_MODEM;
    end
  endfunction : pick

  always_comb begin
    code = pick(req);
    pending = |req;
  end

endmodule : uart_irq_prio

/* File: design/uart_rx_timeout.sv */
`timescale 1ns/1ps
`include "uart_irq_defines.svh"
module uart_rx_timeout #(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Receiver state
  input wire logic fifo_en,
  input wire logic rx_nonempty,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic rx_reset,
  input wire logic bit_tick,
  input wire logic [1:0] word_len,
  // Result
  output logic timeout
);

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic to_reg, to_next;
  logic [CNT_W-1:0] limit;
  logic restart;

  always_comb begin
    limit = CNT_W'(`UART_TO_BASE_BITS + `UART_TO_STEP_BITS * word_len);
    restart = rx_push || rx_pop || rx_reset || !fifo_en;
    cnt_next = cnt_reg;
    to_next = to_reg;
    if (restart || !rx_nonempty) begin
      cnt_next = '0;
      to_next = 1'b0;
    end else if (bit_tick && !to_reg) begin
      cnt_next = cnt_reg + 1'b1;
      // Level vs trigger not looked at, so residue drains
      if (cnt_reg + 1'b1 == limit) begin
        to_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      to_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      to_reg <= to_next;
    end
  end

  assign timeout = to_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_to_fifo_only: assert property (!fifo_en |=> !to_reg)
    else $error("time-out outside FIFO mode");
  a_to_clears: assert property ((rx_pop || rx_push) |=>
    (!to_reg && cnt_reg == '0))
    else $error("time-out not cleared by FIFO access");
  a_to_fires: assert property ((fifo_en && rx_nonempty && !restart &&
    bit_tick && !to_reg && cnt_reg == limit - 1'b1) |=> to_reg)
    else $error("time-out missed at four character times");

endmodule : uart_rx_timeout

/* File: design/uart_interrupt_arbiter.sv */
`timescale 1ns/1ps
`include "uart_irq_defines.svh"
module uart_interrupt_arbiter
  import uart_irq_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LVL_W = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmitter
  input wire logic tx_empty,
  // Receiver
  input wire logic fifo_en,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] rx_trigger,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic rx_reset,
  input wire logic bit_tick,
  input wire logic [1:0] word_len,
  input wire line_err_s line_err,
  // Modem lines
  input wire modem_s modem_in,
  input wire logic autoflow_en,
  // To CPU
  output logic irq
);

  apb_state_e state_reg, state_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [`UART_EN_W-1:0] interrupt_enable_reg, interrupt_enable_next;
  line_err_s err_reg, err_next, err_seen_reg, err_seen_next;
  modem_s delta_reg, delta_next, delta_seen_reg, delta_seen_next;
  modem_s prev_reg, prev_next;
  logic primed_reg, primed_next;
  logic irq_reg, irq_next;
  logic [31:0] interrupt_ident_reg, interrupt_ident_next;
  modem_s change;
  req_s raw, gated;
  int_code_e win_code;
  logic win_pending, to_req, done;
  logic [31:0] rd_val;

  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] ofs);
    is_reg = (a == ADDR_W'(ofs));
  endfunction : is_reg

  uart_rx_timeout u_timeout (
    .pclk(pclk),
    .presetn(presetn),
    .fifo_en(fifo_en),
    .rx_nonempty(rx_level != '0),
    .rx_push(rx_push),
    .rx_pop(rx_pop),
    .rx_reset(rx_reset),
    .bit_tick(bit_tick),
    .word_len(word_len),
    .timeout(to_req)
  );

  // Source conditions before gating
  always_comb begin
    change = primed_reg ? (modem_in ^ prev_reg) : '0;
    raw.tx_empty = tx_empty;
    raw.rx_data = fifo_en ? (rx_level >= rx_trigger && rx_level != '0)
                          : (rx_level != '0);
    raw.rx_timeout = to_req;
    raw.line_status = |err_reg;
    raw.modem_change = (delta_reg.cts && !autoflow_en) || delta_reg.dsr ||
                       delta_reg.ri || delta_reg.dcd;
    gated.tx_empty = raw.tx_empty &&
                     interrupt_enable_reg[`UART_EN_TX_EMPTY];
    gated.rx_data = raw.rx_data &&
                    interrupt_enable_reg[`UART_EN_RX_DATA];
    gated.rx_timeout = raw.rx_timeout &&
                       interrupt_enable_reg[`UART_EN_RX_DATA];
    gated.line_status = raw.line_status &&
                        interrupt_enable_reg[`UART_EN_LINE];
    gated.modem_change = raw.modem_change &&
                         interrupt_enable_reg[`UART_EN_MODEM];
  end

  uart_irq_prio u_prio (
    .req(gated),
    .code(win_code),
    .pending(win_pending)
  );

  // Read mux; time-out has no status bit of its own
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_reg(paddr, `UART_OFS_ENABLE)) begin
      rd_val[`UART_EN_W-1:0] = interrupt_enable_reg;
    end else if (is_reg(paddr, `UART_OFS_IDENT)) begin
      rd_val = interrupt_ident_reg;
    end else if (is_reg(paddr, `UART_OFS_LINE)) begin
      rd_val[`UART_LS_READY] = rx_level != '0;
      rd_val[`UART_LS_ERR_LO +: 4] = err_reg;
      rd_val[`UART_LS_TX_EMPTY] = tx_empty;
    end else if (is_reg(paddr, `UART_OFS_MODEM)) begin
      rd_val[3:0] = delta_reg;
      rd_val[`UART_MS_LVL_LO +: 4] = modem_in;
    end
  end

  // APB: one wait state, answer registered
  always_comb begin
    state_next = state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    done = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (psel && penable) begin
          state_next = ST_ANSWER;
          pready_next = 1'b1;
          prdata_next = pwrite ? 32'h0000_0000 : rd_val;
          pslverr_next = !(is_reg(paddr, `UART_OFS_ENABLE) ||
                           is_reg(paddr, `UART_OFS_IDENT) ||
                           is_reg(paddr, `UART_OFS_LINE) ||
                           is_reg(paddr, `UART_OFS_MODEM));
        end
      end
      ST_ANSWER: begin
        state_next = ST_IDLE;
        done = psel && penable;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Register effects at the completing edge only
  always_comb begin
    interrupt_enable_next = interrupt_enable_reg;
    err_seen_next = err_seen_reg;
    delta_seen_next = delta_seen_reg;
    if (state_reg == ST_IDLE && psel && penable) begin
      err_seen_next = err_reg;
      delta_seen_next = delta_reg;
    end
    if (done && pwrite && is_reg(paddr, `UART_OFS_ENABLE)) begin
      interrupt_enable_next = pwdata[`UART_EN_W-1:0];
    end
    // Clear only what the read returned; a later set is kept
    err_next = err_reg;
    delta_next = delta_reg;
    if (done && !pwrite && is_reg(paddr, `UART_OFS_LINE)) begin
      err_next = err_reg & ~err_seen_reg;
    end
    if (done && !pwrite && is_reg(paddr, `UART_OFS_MODEM)) begin
      delta_next = delta_reg & ~delta_seen_reg;
    end
    err_next = err_next | line_err;
    delta_next = delta_next | change;
    prev_next = modem_in;
    primed_next = 1'b1;
    irq_next = win_pending;
    interrupt_ident_next = 32'h0000_0000;
    interrupt_ident_next[`UART_ID_NONE] = !win_pending;
    interrupt_ident_next[`UART_ID_TYPE_LO +: 3] = win_pending ? win_code
      : INT_MODEM;
    interrupt_ident_next[`UART_ID_FIFO_LO +: 2] = {fifo_en, fifo_en};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_reg <= `UART_EN_RST;
      err_reg <= '0;
      err_seen_reg <= '0;
      delta_reg <= '0;
      delta_seen_reg <= '0;
      prev_reg <= '0;
      primed_reg <= 1'b0;
      irq_reg <= 1'b0;
      interrupt_ident_reg <= `UART_ID_RST;
    end else begin
      interrupt_enable_reg <= interrupt_enable_next;
      err_reg <= err_next;
      err_seen_reg <= err_seen_next;
      delta_reg <= delta_next;
      delta_seen_reg <= delta_seen_next;
      prev_reg <= prev_next;
      primed_reg <= primed_next;
      irq_reg <= irq_next;
      interrupt_ident_reg <= interrupt_ident_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_all_off: assert property ((interrupt_enable_reg == 4'h0) |=>
    (!irq_reg && interrupt_ident_reg[`UART_ID_NONE]))
    else $error("disabled sources still requested");
  a_tx_empty_id: assert property ((tx_empty &&
    interrupt_enable_reg == 4'h2) |=>
    (irq_reg && interrupt_ident_reg[3:1] == 3'h1))
    else $error("transmit-empty not identified");
  a_line_over_rx: assert property ((|err_reg &&
    interrupt_enable_reg[2] && interrupt_enable_reg[0] &&
    rx_level != '0) |=> interrupt_ident_reg[3:1] == 3'h3)
    else $error("receive data outranked line status");
  a_modem_lowest: assert property ((raw.modem_change &&
    interrupt_enable_reg == 4'hA && tx_empty) |=>
    interrupt_ident_reg[3:1] == 3'h1)
    else $error("modem status not lowest");
  a_cts_autoflow: assert property ((interrupt_enable_reg == 4'h8 &&
    autoflow_en && !delta_reg.dsr && !delta_reg.ri && !delta_reg.dcd)
    |=> !irq_reg)
    else $error("CTS change requested under autoflow");
  a_err_sticky: assert property (line_err.overrun |=>
    err_reg.overrun)
    else $error("overrun not recorded");
  a_timeout_id: assert property ((to_req &&
    interrupt_enable_reg == 4'h1 && !raw.rx_data) |=>
    (irq_reg && interrupt_ident_reg[3:1] == 3'h6))
    else $error("time-out not identified");
  a_trig_below: assert property ((fifo_en &&
    interrupt_enable_reg == 4'h1 && rx_level < rx_trigger && !to_req)
    |=> !irq_reg)
    else $error("receive request below trigger level");
  a_apb_wait: assert property ((state_reg == ST_IDLE && psel && penable)
    |=> pready_reg ##1 !pready_reg)
    else $error("APB answer not one cycle wide");

endmodule : uart_interrupt_arbiter

/* File: testbench/irq_host.sv */
`timescale 1ns/1ps
module irq_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Single request line from the block
  input wire logic irq,
  // Requests seen
  output logic [7:0] irq_rises
);
  logic irq_reg;
  // Level line, so only a new rise counts as a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
      irq_rises <= 8'h00;
    end else begin
      irq_reg <= irq;
      if (irq && !irq_reg) begin
        irq_rises <= irq_rises + 8'h01;
      end
    end
  end
endmodule : irq_host

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "uart_irq_defines.svh"
module testbench;
  import uart_irq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, irq_rises;
  logic [31:0] pwdata, prdata, rd;
  logic tx_empty, fifo_en, rx_push, rx_pop, rx_reset, bit_tick;
  logic autoflow_en, irq;
  logic [4:0] rx_level, rx_trigger;
  logic [1:0] word_len;
  line_err_s line_err;
  modem_s modem_in;
  int error_cnt = 0;
  int checked = 0;
  uart_interrupt_arbiter i_uart_interrupt_arbiter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_empty(tx_empty),
    .fifo_en(fifo_en), .rx_level(rx_level), .rx_trigger(rx_trigger),
    .rx_push(rx_push), .rx_pop(rx_pop), .rx_reset(rx_reset),
    .bit_tick(bit_tick), .word_len(word_len), .line_err(line_err),
    .modem_in(modem_in), .autoflow_en(autoflow_en), .irq(irq));
  irq_host i_irq_host (.pclk(pclk), .presetn(presetn), .irq(irq),
    .irq_rises(irq_rises));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Mismatches %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Master waits for pready; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      bit_tick <= 1'b1;
    end
    @(posedge pclk);
    bit_tick <= 1'b0;
    idle(2);
  endtask : ticks
  task automatic set_enable(input logic [31:0] d);
    apb(1'b1, `UART_OFS_ENABLE, d);
    idle(3);
  endtask : set_enable
  initial begin
    idle(20000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_empty, fifo_en, rx_push, rx_pop, rx_reset, bit_tick} = '0;
    {autoflow_en, rx_level, rx_trigger, word_len} = '0;
    line_err = '0;
    modem_in = '0;
    presetn = 1'b0;
    idle(16);
    presetn <= 1'b1;
    rdc("en_rst", `UART_OFS_ENABLE, 32'h0);
    rdc("id_rst", `UART_OFS_IDENT, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    set_enable(32'hFFFF_FFF2);
    rdc("en_wr", `UART_OFS_ENABLE, 32'h2);
    tx_empty <= 1'b1;
    idle(3);
    rdc("id_tx", `UART_OFS_IDENT, 32'h2);
    chk("irq_tx", 1, irq);
    rdc("ls_tx", `UART_OFS_LINE, 32'h20);
    set_enable(32'h0);
    rdc("id_txoff", `UART_OFS_IDENT, 32'h1);
    chk("irq_txoff", 0, irq);
    tx_empty <= 1'b0;
    rx_level <= 5'h01;
    rx_trigger <= 5'h04;
    set_enable(32'h1);
    rdc("id_rx1", `UART_OFS_IDENT, 32'h4);
    ticks(50);
    rdc("id_nofifo", `UART_OFS_IDENT, 32'h4);
    fifo_en <= 1'b1;
    idle(3);
    rdc("id_below", `UART_OFS_IDENT, 32'hC1);
    rdc("ls_ready", `UART_OFS_LINE, 32'h1);
    rx_level <= 5'h04;
    idle(3);
    rdc("id_trig", `UART_OFS_IDENT, 32'hC4);
    rx_level <= 5'h01;
    for (int w = 0; w < 4; w++) begin
      word_len <= w[1:0];
      rx_push <= 1'b1;
      @(posedge pclk);
      rx_push <= 1'b0;
      ticks(31 + 4 * w);
      rdc("to_early", `UART_OFS_IDENT, 32'hC1);
      ticks(2);
      rdc("to_fire", `UART_OFS_IDENT, 32'hCC);
      rdc("ls_to", `UART_OFS_LINE, 32'h1);
      rx_pop <= 1'b1;
      @(posedge pclk);
      rx_pop <= 1'b0;
      idle(3);
      rdc("to_pop", `UART_OFS_IDENT, 32'hC1);
    end
    ticks(50);
    set_enable(32'h0);
    rdc("to_off", `UART_OFS_IDENT, 32'hC1);
    set_enable(32'h1);
    rx_reset <= 1'b1;
    idle(3);
    rdc("to_rrst", `UART_OFS_IDENT, 32'hC1);
    rx_reset <= 1'b0;
    rx_level <= 5'h04;
    for (int i = 0; i < 4; i++) begin
      set_enable(32'h1 | (i == 0 ? 32'h0 : 32'h4));
      line_err <= 4'h1 << i;
      @(posedge pclk);
      line_err <= '0;
      idle(3);
      rdc("id_line", `UART_OFS_IDENT,
          i == 0 ? 32'hC4 : 32'hC6);
      rdc("ls_err", `UART_OFS_LINE, 32'h1 | (32'h2 << i));
      rdc("ls_clr", `UART_OFS_LINE, 32'h1);
    end
    fifo_en <= 1'b0;
    rx_level <= 5'h00;
    autoflow_en <= 1'b1;
    set_enable(32'hA);
    modem_in <= 4'h1;
    idle(3);
    rdc("cts_flow", `UART_OFS_IDENT, 32'h1);
    rdc("ms_cts", `UART_OFS_MODEM, 32'h11);
    autoflow_en <= 1'b0;
    modem_in <= 4'h0;
    idle(3);
    rdc("cts_chg", `UART_OFS_IDENT, 32'h0);
    tx_empty <= 1'b1;
    idle(3);
    rdc("modem_low", `UART_OFS_IDENT, 32'h2);
    tx_empty <= 1'b0;
    rdc("ms_clr", `UART_OFS_MODEM, 32'h1);
    for (int i = 1; i < 4; i++) begin
      modem_in <= 4'h1 << i;
      idle(3);
      rdc("id_mdm", `UART_OFS_IDENT, 32'h0);
      chk("irq_mdm", 1, irq);
      rdc("ms_dlt", `UART_OFS_MODEM, 32'h11 << i);
      modem_in <= 4'h0;
      idle(3);
      rdc("ms_back", `UART_OFS_MODEM, 32'h1 << i);
    end
    idle(3);
    rdc("id_none", `UART_OFS_IDENT, 32'h1);
    chk("irq_none", 0, irq);
    chk("host_seen", 1, irq_rises != 8'h00);
    give_verdict();
  end
endmodule : testbench
